// file: pioab_pkg.sv
// package for the parallel i/o ports a and b block
// assumes an ahb-lite slave with a single word-aligned register per offset
package pioab_pkg;
    localparam logic [7:0] PIOAB_PORT_A_VALUE_OFF = 8'h00;
    localparam logic [7:0] PIOAB_PORT_B_VALUE_OFF = 8'h04;
    localparam logic [7:0] PIOAB_PORT_A_DIR_OFF = 8'h08;
    localparam logic [7:0] PIOAB_PULLDOWN_A_OFF = 8'h0C;
    localparam logic [7:0] PIOAB_OPTION_OFF = 8'h10;
    localparam logic [7:0] PIOAB_IRQ_STATUS_OFF = 8'h14;
    localparam int PIOAB_A_WIDTH = 6;
    localparam int PIOAB_B_WIDTH = 8;
    localparam int PIOAB_IRQ_PINS = 4;
    localparam int PIOAB_LOWER_C_BIT = 6;
    localparam int PIOAB_UPPER_C_BIT = 7;
    localparam int PIOAB_OPT_GLOBAL_PD_BIT = 0;
    localparam int PIOAB_OPT_PORT_IRQ_BIT = 1;
    localparam int PIOAB_OPT_LEVEL_BIT = 2;
    localparam logic [5:0] PIOAB_DIR_RESET = 6'h00;
    localparam logic [7:0] PIOAB_PD_RESET = 8'h00;
    localparam logic [2:0] PIOAB_OPT_RESET = 3'h0;
    typedef enum logic {PIOAB_IDLE, PIOAB_DATA} pioab_phase_e;
endpackage

// file: pioab_top.sv
// parallel i/o ports a and b with ahb-lite register access
// assumes pins synchronous to hclk; pin drive resolved outside
//
// Functional notes
// - six port a pins, per-pin direction
// - output pin drives its value latch
// - input pin reads live pin level
// - port a value top bits read zero
// - reset keeps port a latch contents
// - direction one drives, kills pulldown
// - direction top bits zero, accessible only with ce high
// - reset clears direction, blocks comparators
// - pulldown register is write-only
// - pulldown on when all three zero
// - global disable turns all pulldowns off
// - two bits inhibit port c groups
// - reset clears all inhibit bits
// - pins 0-3 interrupt on high/rise
// - option selects edge or edge+level
// - output pin reads latch value
// - latch writes take effect only with ce high
// - port b eight pins, own address
// - port b drives or reads pins
// - reset keeps port b latch
`timescale 1ns/1ps
module pioab_top
    import pioab_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [5:0] port_a_in,
    output logic [5:0] port_a_out,
    output logic [5:0] port_a_oe,
    output logic [5:0] port_a_pulldown_on,
    input wire logic [7:0] port_b_in,
    output logic [7:0] port_b_out,
    input wire logic [7:0] port_b_dir,
    output logic upper_c_pulldown_inhibit,
    output logic lower_c_pulldown_inhibit,
    output logic global_pulldown_disable,
    output logic comparator_drive_enable,
    output logic port_irq_request
);
    logic [5:0] port_a_value_reg;
    logic [5:0] port_a_direction_reg;
    logic [7:0] pulldown_inhibit_a_reg;
    logic [7:0] port_b_value_reg;
    logic [2:0] option_reg;
    logic [3:0] irq_pending_reg;
    logic [3:0] irq_prev_reg;
    logic comp_enable_reg;
    pioab_phase_e phase_reg;
    logic [7:0] addr_reg;
    logic write_reg;
    logic wr_go;
    logic take;

    function automatic logic [7:0] pioab_mix(input logic [7:0] latch, input logic [7:0] pins,
                                             input logic [7:0] dir);
        pioab_mix = (latch & dir) | (pins & ~dir);
    endfunction

    // ==========================================================
    // bus phase tracking
    assign take = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign wr_go = (phase_reg == PIOAB_DATA) && write_reg && ce;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_reg <= PIOAB_IDLE;
            addr_reg <= 8'h00;
            write_reg <= 1'b0;
        end else if (ce) begin
            case (phase_reg)
                PIOAB_IDLE: phase_reg <= take ? PIOAB_DATA : PIOAB_IDLE;
                PIOAB_DATA: phase_reg <= take ? PIOAB_DATA : PIOAB_IDLE;
                default: phase_reg <= PIOAB_IDLE;
            endcase
            if (take) begin
                addr_reg <= haddr;
                write_reg <= hwrite;
            end
        end
    end

    // ==========================================================
    // data latches, unaffected by reset
    // latches keep through reset
    always_ff @(posedge hclk) begin
        if (wr_go && addr_reg == PIOAB_PORT_A_VALUE_OFF) begin
            port_a_value_reg <= hwdata[5:0];
        end
        if (wr_go && addr_reg == PIOAB_PORT_B_VALUE_OFF) begin
            port_b_value_reg <= hwdata[7:0];
        end
    end

    // ==========================================================
    // control registers
    // reset clears controls
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port_a_direction_reg <= PIOAB_DIR_RESET;
            pulldown_inhibit_a_reg <= PIOAB_PD_RESET;
            option_reg <= PIOAB_OPT_RESET;
            comp_enable_reg <= 1'b0;
        end else if (wr_go) begin
            if (addr_reg == PIOAB_PORT_A_DIR_OFF) begin
                port_a_direction_reg <= hwdata[5:0];
                comp_enable_reg <= 1'b1;
            end
            if (addr_reg == PIOAB_PULLDOWN_A_OFF) begin
                pulldown_inhibit_a_reg <= hwdata[7:0];
            end
            if (addr_reg == PIOAB_OPTION_OFF) begin
                option_reg <= hwdata[2:0];
            end
        end
    end

    // ==========================================================
    // pin drive and pulldowns
    // per-pin drive
    assign port_a_oe = port_a_direction_reg;
    assign port_a_out = port_a_value_reg;
    assign port_b_out = port_b_value_reg;
    assign global_pulldown_disable = option_reg[PIOAB_OPT_GLOBAL_PD_BIT];
    assign comparator_drive_enable = comp_enable_reg;
    assign upper_c_pulldown_inhibit = pulldown_inhibit_a_reg[PIOAB_UPPER_C_BIT];
    assign lower_c_pulldown_inhibit = pulldown_inhibit_a_reg[PIOAB_LOWER_C_BIT];

    genvar gi;
    generate
        for (gi = 0; gi < PIOAB_A_WIDTH; gi++) begin : g_pd
            assign port_a_pulldown_on[gi] = !pulldown_inhibit_a_reg[gi]
                && !port_a_direction_reg[gi] && !global_pulldown_disable;
        end
    endgenerate

    // ==========================================================
    // port a interrupts
    // edge or edge+level detect
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_prev_reg <= 4'h0;
            irq_pending_reg <= 4'h0;
        end else if (ce) begin
            irq_prev_reg <= port_a_in[3:0];
            if (!option_reg[PIOAB_OPT_PORT_IRQ_BIT]) begin
                irq_pending_reg <= 4'h0;
            end else begin
                irq_pending_reg <= (port_a_in[3:0] & ~irq_prev_reg)
                    | (option_reg[PIOAB_OPT_LEVEL_BIT] ? port_a_in[3:0] : 4'h0)
                    | ((wr_go && addr_reg == PIOAB_IRQ_STATUS_OFF)
                       ? (irq_pending_reg & ~hwdata[3:0]) : irq_pending_reg);
            end
        end
    end
    assign port_irq_request = |irq_pending_reg;

    // ==========================================================
    // read data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (ce && take && !hwrite) begin
            case (haddr)
                PIOAB_PORT_A_VALUE_OFF: hrdata <= {24'h0, pioab_mix({2'h0, port_a_value_reg},
                    {2'h0, port_a_in}, {2'h0, port_a_direction_reg})};
                PIOAB_PORT_B_VALUE_OFF: hrdata <= {24'h0, pioab_mix(port_b_value_reg,
                    port_b_in, port_b_dir)};
                PIOAB_PORT_A_DIR_OFF: hrdata <= {26'h0, port_a_direction_reg};
                PIOAB_PULLDOWN_A_OFF: hrdata <= 32'h0000_0000;
                PIOAB_OPTION_OFF: hrdata <= {29'h0, option_reg};
                PIOAB_IRQ_STATUS_OFF: hrdata <= {28'h0, irq_pending_reg};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // ==========================================================
    // checks
    AST_PD_OFF_WHEN_OUT: assert property (@(posedge hclk) disable iff (!hresetn)
        port_a_direction_reg[0] |-> !port_a_pulldown_on[0])
        else $error("pulldown on while output");
    AST_GLOBAL_PD: assert property (@(posedge hclk) disable iff (!hresetn)
        global_pulldown_disable |-> port_a_pulldown_on == 6'h00)
        else $error("pulldown on with global disable");
    AST_PD_ON: assert property (@(posedge hclk) disable iff (!hresetn)
        (pulldown_inhibit_a_reg[1] == 1'b0 && !port_a_direction_reg[1]
         && !global_pulldown_disable) |-> port_a_pulldown_on[1])
        else $error("pulldown off unexpectedly");
    AST_DRIVE: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_go && addr_reg == PIOAB_PORT_A_VALUE_OFF)
        |=> port_a_out == $past(hwdata[5:0]))
        else $error("pin not driven from latch");
    AST_READ_TOP_ZERO: assert property (@(posedge hclk) disable iff (!hresetn)
        $past(take && !hwrite && haddr == PIOAB_PORT_A_VALUE_OFF && ce)
        |-> hrdata[7:6] == 2'h0)
        else $error("port a top bits nonzero");
    AST_DIR_TOP_ZERO: assert property (@(posedge hclk) disable iff (!hresetn)
        $past(take && !hwrite && haddr == PIOAB_PORT_A_DIR_OFF && ce)
        |-> hrdata[7:6] == 2'h0)
        else $error("direction top bits nonzero");
    AST_PD_READ_ZERO: assert property (@(posedge hclk) disable iff (!hresetn)
        $past(take && !hwrite && haddr == PIOAB_PULLDOWN_A_OFF && ce) |-> hrdata == 32'h0)
        else $error("pulldown read nonzero");
    AST_IRQ_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
        $past(!option_reg[PIOAB_OPT_PORT_IRQ_BIT] && ce) |-> !port_irq_request)
        else $error("irq while option off");
    AST_LATCH_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_go && addr_reg == PIOAB_PORT_B_VALUE_OFF) |=> port_b_out == $past(hwdata[7:0]))
        else $error("port b latch not written");

    // ==========================================================
    // pulldown and control register checks

    AST_PD_OFF_ALL: assert property (@(posedge hclk) disable iff (!hresetn)
        (port_a_pulldown_on & port_a_oe) == 6'h00)
        else $error("pulldown on for an output pin");

    AST_PD_INHIBIT: assert property (@(posedge hclk) disable iff (!hresetn)
        (port_a_pulldown_on & pulldown_inhibit_a_reg[5:0]) == 6'h00)
        else $error("pulldown on while inhibited");

    AST_C_INHIBIT_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_go && addr_reg == PIOAB_PULLDOWN_A_OFF)
        |=> {upper_c_pulldown_inhibit, lower_c_pulldown_inhibit} == $past(hwdata[7:6]))
        else $error("port c inhibits not written");

    AST_DIR_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_go && addr_reg == PIOAB_PORT_A_DIR_OFF)
        |=> port_a_oe == $past(hwdata[5:0]))
        else $error("direction not written");

    AST_OPT_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_go && addr_reg == PIOAB_OPTION_OFF)
        |=> global_pulldown_disable == $past(hwdata[PIOAB_OPT_GLOBAL_PD_BIT]))
        else $error("global disable not written");

    // ==========================================================
    // read path checks

    AST_READ_PIN: assert property (@(posedge hclk) disable iff (!hresetn)
        $past(take && !hwrite && ce && haddr == PIOAB_PORT_A_VALUE_OFF
              && port_a_direction_reg == 6'h00)
        |-> hrdata[5:0] == $past(port_a_in))
        else $error("input pin level not read");

    AST_READ_LATCH: assert property (@(posedge hclk) disable iff (!hresetn)
        $past(take && !hwrite && ce && haddr == PIOAB_PORT_A_VALUE_OFF
              && port_a_direction_reg == 6'h3F)
        |-> hrdata[5:0] == $past(port_a_out))
        else $error("output latch not read");

    AST_READ_HIGH_ZERO: assert property (@(posedge hclk) disable iff (!hresetn)
        $past(take && !hwrite && ce)
        |-> hrdata[31:8] == 24'h000000)
        else $error("upper read bits nonzero");

    AST_READ_B_OUT: assert property (@(posedge hclk) disable iff (!hresetn)
        $past(take && !hwrite && ce && haddr == PIOAB_PORT_B_VALUE_OFF
              && port_b_dir == 8'hFF)
        |-> hrdata[7:0] == $past(port_b_out))
        else $error("port b latch not read");

    AST_READ_B_PIN: assert property (@(posedge hclk) disable iff (!hresetn)
        $past(take && !hwrite && ce && haddr == PIOAB_PORT_B_VALUE_OFF
              && port_b_dir == 8'h00)
        |-> hrdata[7:0] == $past(port_b_in))
        else $error("port b pin level not read");

    AST_DIR_READ: assert property (@(posedge hclk) disable iff (!hresetn)
        $past(take && !hwrite && ce && haddr == PIOAB_PORT_A_DIR_OFF)
        |-> hrdata[5:0] == $past(port_a_oe))
        else $error("direction read wrong");

    AST_HRDATA_STANDS: assert property (@(posedge hclk) disable iff (!hresetn)
        !(take && !hwrite && ce)
        |=> $stable(hrdata))
        else $error("read data moved without a read");

    // ==========================================================
    // bus phase and enable checks

    AST_PHASE_DATA: assert property (@(posedge hclk) disable iff (!hresetn)
        (take && ce)
        |=> phase_reg == PIOAB_DATA)
        else $error("data phase missed");

    AST_PHASE_IDLE: assert property (@(posedge hclk) disable iff (!hresetn)
        (!take && ce)
        |=> phase_reg == PIOAB_IDLE)
        else $error("phase not idle");

    AST_ADDR_CAPTURE: assert property (@(posedge hclk) disable iff (!hresetn)
        (take && ce)
        |=> addr_reg == $past(haddr) && write_reg == $past(hwrite))
        else $error("address phase not captured");

    AST_CE_FREEZE: assert property (@(posedge hclk) disable iff (!hresetn)
        !ce
        |=> $stable(port_a_oe) && $stable(hrdata) && $stable(phase_reg))
        else $error("state moved with enable low");

    // ==========================================================
    // interrupt checks

    AST_IRQ_EDGE: assert property (@(posedge hclk) disable iff (!hresetn)
        (ce && option_reg[PIOAB_OPT_PORT_IRQ_BIT]
         && (port_a_in[3:0] & ~irq_prev_reg) != 4'h0)
        |=> port_irq_request)
        else $error("rising edge not flagged");

    AST_IRQ_LEVEL: assert property (@(posedge hclk) disable iff (!hresetn)
        (ce && option_reg[PIOAB_OPT_PORT_IRQ_BIT] && option_reg[PIOAB_OPT_LEVEL_BIT]
         && port_a_in[3:0] != 4'h0)
        |=> port_irq_request)
        else $error("high level not flagged");

    AST_IRQ_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
        (ce && option_reg[PIOAB_OPT_PORT_IRQ_BIT] && !option_reg[PIOAB_OPT_LEVEL_BIT]
         && (port_a_in[3:0] & ~irq_prev_reg) == 4'h0
         && wr_go && addr_reg == PIOAB_IRQ_STATUS_OFF && hwdata[3:0] == 4'hF)
        |=> !port_irq_request)
        else $error("edge flag not cleared");

    AST_IRQ_QUIET: assert property (@(posedge hclk) disable iff (!hresetn)
        (ce && !port_irq_request && port_a_in[3:0] == 4'h0)
        |=> !port_irq_request)
        else $error("request with low pins");

    // ==========================================================
    // comparator gating check

    AST_COMP_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
        comparator_drive_enable
        |-> $past(comparator_drive_enable)
            || $past(wr_go && addr_reg == PIOAB_PORT_A_DIR_OFF))
        else $error("comparators enabled without direction write");

endmodule

// file: pioab_pins.sv
// pin-side model of the circuits hung on ports a and b
// assumes dut pin outputs settle between clock edges
`timescale 1ns/1ps
module pioab_pins (
    input wire logic clk,
    input wire logic [5:0] port_a_out,
    input wire logic [5:0] port_a_oe,
    input wire logic [5:0] port_a_pulldown_on,
    input wire logic [5:0] ext_a_en,
    input wire logic [5:0] ext_a_val,
    output logic [5:0] port_a_in,
    input wire logic [7:0] port_b_out,
    input wire logic [7:0] port_b_dir,
    input wire logic [7:0] ext_b_val,
    output logic [7:0] port_b_in
);
    logic [5:0] float_reg = 6'h15;
    // floating pin without pulldown wanders every cycle
    always @(posedge clk) begin
        float_reg <= ~port_a_in;
    end
    // wire level from every driver on the pin
    always_comb begin
        port_a_in = (port_a_oe & port_a_out) | (~port_a_oe & ext_a_en & ext_a_val)
            | (~port_a_oe & ~ext_a_en & ~port_a_pulldown_on & float_reg);
        port_b_in = (port_b_dir & port_b_out) | (~port_b_dir & ext_b_val);
    end
endmodule

// file: testbench.sv
// self-checking bench for parallel i/o ports a and b
// assumes a zero-wait ahb-lite slave and the pin model beside it
`timescale 1ns/1ps
module testbench;
    import pioab_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic ce = 1'b1;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h00000000;
    logic [31:0] hrdata, rq;
    logic hreadyout, hresp, up_c, lo_c, gpd, cmp_en, irq;
    logic [5:0] pa_in, pa_out, pa_oe, pa_pd;
    logic [5:0] ext_a_en = 6'h00;
    logic [5:0] ext_a_val = 6'h00;
    logic [7:0] pb_in, pb_out;
    logic [7:0] port_b_dir = 8'h00;
    logic [7:0] ext_b_val = 8'h00;
    int num_errors = 0;
    int n_tests = 0;
    logic [31:0] rows [5][3] = '{'{32'h08, 32'hFF, 32'h3F}, '{32'h00, 32'hFF, 32'h3F},
        '{32'h0C, 32'hFF, 32'h00}, '{32'h04, 32'hA5, 32'hA5}, '{32'h1C, 32'hFF, 32'h00}};
    always #2.5 hclk = ~hclk;
    pioab_top dut_u (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .port_a_in(pa_in),
        .port_a_out(pa_out), .port_a_oe(pa_oe), .port_a_pulldown_on(pa_pd),
        .port_b_in(pb_in), .port_b_out(pb_out), .port_b_dir(port_b_dir),
        .upper_c_pulldown_inhibit(up_c), .lower_c_pulldown_inhibit(lo_c),
        .global_pulldown_disable(gpd), .comparator_drive_enable(cmp_en),
        .port_irq_request(irq));
    pioab_pins pins_u (.clk(hclk), .port_a_out(pa_out), .port_a_oe(pa_oe),
        .port_a_pulldown_on(pa_pd), .ext_a_en(ext_a_en), .ext_a_val(ext_a_val),
        .port_a_in(pa_in), .port_b_out(pb_out), .port_b_dir(port_b_dir),
        .ext_b_val(ext_b_val), .port_b_in(pb_in));
    // ==========================================
    // bus and compare tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rq = hrdata;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h00000000);
        chk(rq, e);
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #20000;
        num_errors++;
        give_verdict();
    end
    // ==========================================
    // table rows, then hand-written cases
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        port_b_dir <= 8'hFF;
        for (int i = 0; i < 5; i++) begin
            ahb(1'b1, rows[i][0][7:0], rows[i][1]);
            rd(rows[i][0][7:0], rows[i][2]);
        end
        $display("test table done");
        chk({pa_oe, pa_out, pa_pd}, 32'h3FFC0);
        chk({pb_out, 7'h00, cmp_en}, 32'hA501);
        ahb(1'b1, 8'h08, 32'h00);
        ext_a_en <= 6'h3F;
        ext_a_val <= 6'h2A;
        ext_b_val <= 8'h3C;
        port_b_dir <= 8'h00;
        ahb(1'b1, 8'h00, 32'h15);
        rd(8'h00, 32'h2A);
        rd(8'h04, 32'h3C);
        ahb(1'b1, 8'h08, 32'h3F);
        chk(pa_out, 32'h15);
        $display("test inputs done");
        ahb(1'b1, 8'h08, 32'h00);
        // software rewrites the inhibit register whole, never read-modify-write
        ahb(1'b1, 8'h0C, 32'h05);
        chk(pa_pd, 32'h3A);
        ahb(1'b1, 8'h10, 32'h01);
        chk({gpd, pa_pd}, 32'h40);
        ahb(1'b1, 8'h10, 32'h00);
        ahb(1'b1, 8'h0C, 32'h40);
        chk({up_c, lo_c, pa_pd}, 32'h7F);
        $display("test pulldowns done");
        ext_a_val <= 6'h00;
        ahb(1'b1, 8'h10, 32'h02);
        ahb(1'b1, 8'h14, 32'h0F);
        ext_a_val <= 6'h01;
        repeat (3) @(posedge hclk);
        chk(irq, 32'h1);
        ahb(1'b1, 8'h14, 32'h0F);
        repeat (3) @(posedge hclk);
        chk(irq, 32'h0);
        ahb(1'b1, 8'h10, 32'h06);
        repeat (3) @(posedge hclk);
        chk(irq, 32'h1);
        $display("test interrupts done");
        ce <= 1'b0;
        ahb(1'b1, 8'h00, 32'h2A);
        ce <= 1'b1;
        chk(pa_out, 32'h15);
        $display("test enable done");
        ahb(1'b1, 8'h08, 32'h3F);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        #1;
        chk({pa_oe, pa_out, pa_pd}, 32'h0057F);
        chk({pb_out, up_c, lo_c, cmp_en, irq}, 32'hA50);
        hresetn <= 1'b1;
        $display("test reset done");
        give_verdict();
    end
endmodule
